// file: eeprom_cfg.svh
// constants for the serial eeprom write slave
// assumes inclusion by bare name from the design files
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

`define DEV_TYPE 4'ha
`define ADDR_W 13
`define PAGE_W 5
`define HI_ADDR_W 5
`define BYTE_BITS 4'h8
`define PIN_CNT 6
`define PIN_RST 6'h30
`define PROG_BUSY_TIME_US 6000
`define MCLK_MHZ 250
`define PROG_BUSY_CYCLES (`PROG_BUSY_TIME_US * `MCLK_MHZ)

`endif

// file: eeprom_pkg.sv
// types for the serial eeprom write slave
// assumes nothing beyond a systemverilog compiler
`default_nettype none

package eeprom_pkg;
    typedef enum logic [2:0] {st_idle, st_rx, st_ack, st_busy, st_commit} state_e;
    typedef enum logic [1:0] {ph_dev, ph_hi, ph_lo, ph_data} phase_e;
endpackage : eeprom_pkg

`default_nettype wire

// file: serial_eeprom_i2c_write_slave.sv
// two-wire write slave front end of an 8k x 8 serial eeprom
// assumes scl/sda/pins are asynchronous to mclk_i; the array sits outside
//
// Functional notes
// - bits shift on the serial clock rising edges
// - data line only pulled low or released
// - data changes only while clock low
// - start is data falling with clock high
// - stop ends transfer, enters standby
// - select bits must match chip-select pins
// - two address bytes, thirteen bits used
// - acknowledge address, both address bytes, data
// - stop after data starts programming cycle
// - pages of 32 aligned bytes
// - each data byte acked, address advances
// - address wraps inside current page
// - page write may start mid-page
// - extra bytes overwrite earlier page positions
// - protect high blocks all programming
// - protected: address acked, data not acked
// - floating protect input reads as unprotected (no pull-down here; write_protect_i is used as driven)
// - device type must be 1-0-1-0
// - last address bit: one read, zero write
// - receiver pulls data low on ninth clock
// - busy 6 ms, no ack, line released
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cfg.svh"

module serial_eeprom_i2c_write_slave
    import eeprom_pkg::*;
#(
    parameter int BUSY_CYCLES = `PROG_BUSY_CYCLES
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic write_protect_i,
    input wire logic chip_select_bit2_i,
    input wire logic chip_select_bit1_i,
    input wire logic chip_select_bit0_i,
    output logic busy_o,
    output logic standby_o,
    output logic mem_we_o,
    output logic [`ADDR_W-1:0] mem_addr_o,
    output logic [7:0] mem_data_o
);
    localparam int BUSY_W = $clog2(BUSY_CYCLES);

    generate
        if (BUSY_CYCLES < 2) begin : g_bad_busy
            $error("BUSY_CYCLES must be at least 2");
        end
    endgenerate

    // pin filters: three flops, new level once second and third agree
    logic [`PIN_CNT-1:0] pin_raw;
    logic [`PIN_CNT-1:0] pin_f;
    assign pin_raw = {scl_i, sda_i, write_protect_i,
                      chip_select_bit2_i, chip_select_bit1_i, chip_select_bit0_i};

    genvar g;
    generate
        for (g = 0; g < `PIN_CNT; g++) begin : g_sync
            localparam logic [`PIN_CNT-1:0] RST_V = `PIN_RST;
            logic [2:0] sh;
            logic f;
            always_ff @(posedge mclk_i or posedge rst_i) begin
                if (rst_i) begin
                    // flops start at the idle level so no false edge follows reset
                    sh <= {3{RST_V[g]}};
                    f <= RST_V[g];
                end else if (clk_en_i) begin
                    sh <= {sh[1:0], pin_raw[g]};
                    if (sh[1] == sh[2]) begin
                        f <= sh[2];
                    end
                end
            end
            assign pin_f[g] = f;
        end
    endgenerate

    logic scl_f;
    logic sda_f;
    logic wp_f;
    logic [2:0] cs_f;
    assign scl_f = pin_f[5];
    assign sda_f = pin_f[4];
    assign wp_f = pin_f[3];
    assign cs_f = pin_f[2:0];

    logic scl_q;
    logic sda_q;
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else if (clk_en_i) begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_f & ~scl_q;
    assign scl_fall = ~scl_f & scl_q;
    assign start_ev = scl_f & scl_q & sda_q & ~sda_f;
    assign stop_ev = scl_f & scl_q & ~sda_q & sda_f;

    state_e state;
    phase_e phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic [`ADDR_W-1:0] addr;
    logic pending;
    logic busy_done;
    logic [`PAGE_W-1:0] commit_idx;
    logic in_xfer;
    logic bit_done;
    logic dev_match;
    logic ack_ok;

    assign in_xfer = (state == st_rx) || (state == st_ack);
    assign bit_done = (state == st_rx) && scl_fall && (bit_cnt == `BYTE_BITS);
    // reads are served elsewhere, so only a write address is claimed
    assign dev_match = (shreg[7:4] == `DEV_TYPE)
                       && (shreg[3:1] == cs_f)
                       && !shreg[0];

    always_comb begin
        unique case (phase)
            ph_dev: ack_ok = dev_match;
            ph_hi: ack_ok = 1'b1;
            ph_lo: ack_ok = 1'b1;
            ph_data: ack_ok = !wp_f;
        endcase
    end

    // bus sequencing: bytes, acknowledges, start and stop handling
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= st_idle;
            phase <= ph_dev;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            addr <= '0;
            pending <= 1'b0;
            sda_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            if (start_ev && state != st_busy && state != st_commit) begin
                state <= st_rx;
                phase <= ph_dev;
                bit_cnt <= 4'h0;
                pending <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (stop_ev && in_xfer) begin
                state <= pending ? st_busy : st_idle;
                sda_oe_o <= 1'b0;
            end else begin
                unique case (state)
                    st_idle: begin
                        sda_oe_o <= 1'b0;
                    end
                    st_rx: begin
                        if (scl_rise) begin
                            shreg <= {shreg[6:0], sda_f};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (bit_done) begin
                            if (ack_ok) begin
                                sda_oe_o <= 1'b1;
                                state <= st_ack;
                                unique case (phase)
                                    ph_dev: begin
                                    end
                                    ph_hi: begin
                                        addr[`ADDR_W-1:8] <= shreg[`HI_ADDR_W-1:0];
                                    end
                                    ph_lo: begin
                                        addr[7:0] <= shreg;
                                    end
                                    ph_data: begin
                                        addr[`PAGE_W-1:0] <= addr[`PAGE_W-1:0] + 5'h01;
                                        pending <= 1'b1;
                                    end
                                endcase
                            end else begin
                                state <= st_idle;
                            end
                        end
                    end
                    st_ack: begin
                        if (scl_fall) begin
                            sda_oe_o <= 1'b0;
                            state <= st_rx;
                            bit_cnt <= 4'h0;
                            unique case (phase)
                                ph_dev: phase <= ph_hi;
                                ph_hi: phase <= ph_lo;
                                ph_lo: phase <= ph_data;
                                ph_data: phase <= ph_data;
                            endcase
                        end
                    end
                    st_busy: begin
                        sda_oe_o <= 1'b0;
                        if (busy_done) begin
                            state <= st_commit;
                        end
                    end
                    st_commit: begin
                        if (commit_idx == 5'h1f) begin
                            state <= st_idle;
                            pending <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // page buffer: bytes land at their page position, later ones replace
    logic [7:0] page_buf [2**`PAGE_W];
    logic [2**`PAGE_W-1:0] page_mask;
    always_ff @(posedge mclk_i) begin
        if (clk_en_i && bit_done && ack_ok && phase == ph_data) begin
            page_buf[addr[`PAGE_W-1:0]] <= shreg;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            page_mask <= '0;
        end else if (clk_en_i) begin
            if (start_ev && in_xfer || state == st_idle && start_ev) begin
                page_mask <= '0;
            end else if (bit_done && ack_ok && phase == ph_data) begin
                page_mask[addr[`PAGE_W-1:0]] <= 1'b1;
            end
        end
    end

    // busy timer
    logic [BUSY_W-1:0] busy_cnt;
    assign busy_done = (busy_cnt == BUSY_W'(BUSY_CYCLES - 1));
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_cnt <= '0;
        end else if (clk_en_i) begin
            if (state == st_busy) begin
                busy_cnt <= busy_cnt + 1'b1;
            end else begin
                busy_cnt <= '0;
            end
        end
    end

    // commit walks the page and writes only loaded positions
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            commit_idx <= '0;
            mem_we_o <= 1'b0;
            mem_addr_o <= '0;
            mem_data_o <= 8'h00;
        end else if (clk_en_i) begin
            mem_we_o <= 1'b0;
            if (state == st_commit) begin
                commit_idx <= commit_idx + 5'h01;
                mem_we_o <= page_mask[commit_idx];
                mem_addr_o <= {addr[`ADDR_W-1:`PAGE_W], commit_idx};
                mem_data_o <= page_buf[commit_idx];
            end else begin
                commit_idx <= '0;
            end
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o <= 1'b0;
            busy_o <= 1'b0;
            standby_o <= 1'b1;
        end else if (clk_en_i) begin
            sda_o <= 1'b0;
            busy_o <= (state == st_busy) || (state == st_commit);
            standby_o <= (state == st_idle);
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i || !clk_en_i);

    property p_oe_only_ack;
        sda_oe_o |-> state == st_ack;
    endproperty
    a_oe_only_ack: assert property (p_oe_only_ack) else $error("data line pulled outside ack");

    property p_busy_quiet;
        state == st_busy |-> !sda_oe_o && busy_cnt <= BUSY_W'(BUSY_CYCLES - 1);
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("pulled line while busy");

    property p_wp_no_data_ack;
        $rose(sda_oe_o) && phase == ph_data |-> !wp_f;
    endproperty
    a_wp_no_data_ack: assert property (p_wp_no_data_ack) else $error("data acked while protected");

    property p_addr_match;
        $rose(sda_oe_o) && phase == ph_dev |-> shreg == {`DEV_TYPE, cs_f, 1'b0};
    endproperty
    a_addr_match: assert property (p_addr_match) else $error("acked wrong slave address");

    property p_addr_step;
        $rose(sda_oe_o) && phase == ph_data |->
            addr[4:0] == $past(addr[4:0]) + 5'h01 && addr[12:5] == $past(addr[12:5]);
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("address not stepped in page");

    property p_stop_busy;
        stop_ev && in_xfer && pending |=> state == st_busy;
    endproperty
    a_stop_busy: assert property (p_stop_busy) else $error("no busy after write stop");

    property p_stop_idle;
        stop_ev && in_xfer && !pending |=> state == st_idle && !busy_o [*2];
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("busy without accepted data");

    property p_commit_page;
        mem_we_o |-> busy_o && mem_addr_o[12:5] == addr[12:5];
    endproperty
    a_commit_page: assert property (p_commit_page) else $error("commit outside page or busy");

endmodule : serial_eeprom_i2c_write_slave

`default_nettype wire

// file: bus_master_model.sv
// two-wire bus master model driving the eeprom write slave
// assumes the bench ands every open-drain pull into sda_line_i (pull-up)
`timescale 1ns/1ps
`default_nettype none

module bus_master_model #(
    parameter realtime QTR = 31.25
) (
    output var logic scl_o,
    output var logic sda_o,
    input wire logic sda_line_i
);
    // clock stands high and data released between frames
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end

    task automatic start_cond;
        sda_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b0;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : start_cond

    task automatic send_bit(input logic b);
        sda_o = b;
        #QTR scl_o = 1'b1;
        #(2 * QTR) scl_o = 1'b0;
        #QTR;
    endtask : send_bit

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            send_bit(b[i]);
        end
        sda_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR ack = ~sda_line_i;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : send_byte

    task automatic stop_cond;
        sda_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_o = 1'b1;
        #QTR;
    endtask : stop_cond
endmodule : bus_master_model

`default_nettype wire

// file: serial_eeprom_i2c_write_slave_tb.sv
// self-checking bench for the eeprom write slave
// assumes bus_master_model on the far side; busy period shortened
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_cfg.svh"

module serial_eeprom_i2c_write_slave_tb;
    import eeprom_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic write_protect_i = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] cs = 3'h5;
    wire logic scl, m_sda, sda_line, sda_o, sda_oe_o, busy_o, standby_o, mem_we_o;
    wire logic [`ADDR_W-1:0] mem_addr_o;
    wire logic [7:0] mem_data_o;
    logic [`ADDR_W-1:0] wa[$];
    logic [7:0] wd[$];
    int fails = 0;
    int n_tests = 0;

    assign sda_line = (sda_oe_o === 1'b1 ? sda_o : 1'b1) & m_sda;
    always #2 mclk_i = ~mclk_i;

    bus_master_model bus_master_model_inst (.scl_o(scl), .sda_o(m_sda), .sda_line_i(sda_line));

    serial_eeprom_i2c_write_slave #(.BUSY_CYCLES(2000)) serial_eeprom_i2c_write_slave_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .clk_en_i(clk_en), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .write_protect_i(write_protect_i),
        .chip_select_bit2_i(cs[2]), .chip_select_bit1_i(cs[1]), .chip_select_bit0_i(cs[0]),
        .busy_o(busy_o), .standby_o(standby_o), .mem_we_o(mem_we_o),
        .mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // committed bytes are collected; the data pin may only ever pull low
    always @(posedge mclk_i) begin
        if (mem_we_o === 1'b1) begin
            wa.push_back(mem_addr_o);
            wd.push_back(mem_data_o);
        end
        if (sda_oe_o === 1'b1) begin
            check("sda_o", {31'h0, sda_o}, 32'h0);
        end
    end

    task automatic sendb(input logic [7:0] b, input logic exp_ack, input string what);
        logic ack;
        bus_master_model_inst.send_byte(b, ack);
        check(what, {31'h0, ack}, {31'h0, exp_ack});
    endtask : sendb

    task automatic wait_idle;
        int n;
        n = 0;
        while (busy_o !== 1'b0 && n < 5000) begin
            @(posedge mclk_i);
            n++;
        end
        if (n >= 5000) begin
            check("busy timeout", 32'h1, 32'h0);
            final_report();
        end
    endtask : wait_idle

    task automatic byte_write;
        wa.delete();
        wd.delete();
        bus_master_model_inst.start_cond();
        sendb(8'haa, 1'b1, "dev ack");
        sendb(8'hf2, 1'b1, "hi ack");
        sendb(8'h34, 1'b1, "lo ack");
        sendb(8'ha5, 1'b1, "data ack");
        bus_master_model_inst.stop_cond();
        check("busy", {31'h0, busy_o}, 32'h1);
        wait_idle();
        check("we count", wa.size(), 32'h1);
        check("addr", wa[0], 32'h1234);
        check("data", wd[0], 32'ha5);
    endtask : byte_write

    task automatic refusals;
        logic [7:0] dev[4] = '{8'hac, 8'ha6, 8'hbc, 8'had};
        logic exp[4] = '{1'b1, 1'b0, 1'b0, 1'b0};
        @(posedge mclk_i);
        cs <= 3'h6;
        repeat (8) @(posedge mclk_i);
        for (int i = 0; i < 4; i++) begin
            bus_master_model_inst.start_cond();
            sendb(dev[i], exp[i], "select");
            bus_master_model_inst.stop_cond();
            check("standby", {31'h0, standby_o}, 32'h1);
            check("no busy", {31'h0, busy_o}, 32'h0);
        end
        @(posedge mclk_i);
        cs <= 3'h5;
        repeat (8) @(posedge mclk_i);
    endtask : refusals

    task automatic page_write;
        wa.delete();
        wd.delete();
        bus_master_model_inst.start_cond();
        sendb(8'haa, 1'b1, "dev ack");
        sendb(8'h00, 1'b1, "hi ack");
        sendb(8'h5e, 1'b1, "lo ack");
        // two bytes past a full page exercise the wrap and overwrite
        for (int k = 0; k < 34; k++) begin
            sendb(8'h10 + 8'(k), 1'b1, "page ack");
        end
        bus_master_model_inst.stop_cond();
        bus_master_model_inst.start_cond();
        sendb(8'haa, 1'b0, "busy poll");
        bus_master_model_inst.stop_cond();
        check("busy held", {31'h0, busy_o}, 32'h1);
        // clock enable low must freeze the busy timer past its full length
        @(posedge mclk_i);
        clk_en <= 1'b0;
        repeat (2500) @(posedge mclk_i);
        check("frozen busy", {31'h0, busy_o}, 32'h1);
        check("frozen commit", wa.size(), 32'h0);
        clk_en <= 1'b1;
        wait_idle();
        check("page count", wa.size(), 32'h20);
        for (int p = 0; p < 32 && p < wa.size(); p++) begin
            check("page addr", wa[p], 32'h40 + 32'(p));
            check("page data", wd[p], 32'h12 + 32'(p));
        end
    endtask : page_write

    task automatic protect_and_early_stop;
        wa.delete();
        @(posedge mclk_i);
        write_protect_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        bus_master_model_inst.start_cond();
        sendb(8'haa, 1'b1, "wp dev ack");
        sendb(8'h00, 1'b1, "wp hi ack");
        sendb(8'h10, 1'b1, "wp lo ack");
        sendb(8'h77, 1'b0, "wp data nack");
        bus_master_model_inst.stop_cond();
        check("wp busy", {31'h0, busy_o}, 32'h0);
        @(posedge mclk_i);
        write_protect_i <= 1'b0;
        repeat (8) @(posedge mclk_i);
        bus_master_model_inst.start_cond();
        sendb(8'haa, 1'b1, "dev ack");
        sendb(8'h00, 1'b1, "hi ack");
        sendb(8'h10, 1'b1, "lo ack");
        bus_master_model_inst.stop_cond();
        repeat (10) @(posedge mclk_i);
        check("early stop busy", {31'h0, busy_o}, 32'h0);
        check("no commit", wa.size(), 32'h0);
    endtask : protect_and_early_stop

    initial begin
        repeat (19) @(posedge mclk_i);
        check("rst standby", {31'h0, standby_o}, 32'h1);
        check("rst oe", {31'h0, sda_oe_o}, 32'h0);
        @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        #1;
        byte_write();
        refusals();
        page_write();
        protect_and_early_stop();
        final_report();
    end
endmodule : serial_eeprom_i2c_write_slave_tb

`default_nettype wire
